// ===== logic/fifo_wm_pkg.sv
// package with register map, field layout and bus types of the shared byte fifo
package fifo_wm_pkg;

    // ------------------------------------------------------------------
    // storage geometry
    // ------------------------------------------------------------------
    localparam int         DEPTH      = 512;
    localparam int         PTR_W      = 9;
    localparam int         CNT_W      = 10;
    localparam logic [9:0] CAP_FULL   = 10'h200;
    localparam logic [9:0] CAP_SMALL  = 10'h0FF;

    // ------------------------------------------------------------------
    // register indices, byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [5:0] IDX_CTRL   = 6'h02;  // buf_ctrl_reg
    localparam logic [5:0] IDX_WM     = 6'h03;  // fifo_watermark_low
    localparam logic [5:0] IDX_FILL   = 6'h04;  // buf_fill_count low byte
    localparam logic [5:0] IDX_DATA   = 6'h05;  // data port, write pushes, read pops
    localparam logic [5:0] IDX_STAT   = 6'h06;  // irq_status_reg0
    localparam logic [5:0] IDX_CLR    = 6'h07;  // status clear, write one to clear
    localparam logic [5:0] IDX_IEN    = 6'h08;  // irq_enable_reg0

    // ------------------------------------------------------------------
    // buf_ctrl_reg fields
    // ------------------------------------------------------------------
    localparam int CTRL_FLUSH_POS   = 0;
    localparam int CTRL_LIMIT_POS   = 1;
    localparam int CTRL_WM_HI_POS   = 2;
    localparam int CTRL_AE_POS      = 3;
    localparam int CTRL_AF_POS      = 4;
    localparam int CTRL_OVF_POS     = 5;
    localparam int CTRL_FILL_HI_POS = 6;

    // ------------------------------------------------------------------
    // interrupt status / clear / enable fields
    // ------------------------------------------------------------------
    localparam int IRQ_ERR_POS = 0;
    localparam int IRQ_AE_POS  = 1;
    localparam int IRQ_AF_POS  = 2;
    localparam int IRQ_W       = 3;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [8:0] WM_RST      = 9'h000;
    localparam logic [2:0] IEN_RST     = 3'h0;
    localparam logic       AE_PREV_RST = 1'b1;  // empty fifo is almost empty after reset
    localparam logic       AF_PREV_RST = 1'b0;

    // ------------------------------------------------------------------
    // bus answers and carriers
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic [31:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [31:0] araddr;
        logic        arvalid;
        logic        rready;
    } axil_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } axil_rsp_s;

endpackage

// ===== logic/shared_fifo_watermark.sv
// shared 512 x 8 fifo with watermark alerts, overflow error and axi4-lite registers
`timescale 1ns/1ns

// Overview of operation
// - one 512-deep byte buffer queues data between host port and state machine
// - with size-limit bit set, capacity is 255 and level/watermark fit one byte
// - in 512 mode level and watermark need a second byte for upper bits
// - writing one to flush resets both pointers and clears fill level
// - fill level rises by one per byte written while not full, falls by one per read while not empty
// - almost-full is high when capacity minus level is at most watermark
// - almost-empty is high when level is at most watermark
// - byte written into full buffer sets overflow and error interrupt status
// - enabled almost-empty rising edge raises the interrupt output
// - enabled almost-full rising edge raises the interrupt output
// - one watermark serves both thresholds, from top and from bottom
// - watermark is low byte at index 03h plus bit 2 of index 02h
module shared_fifo_watermark
    import fifo_wm_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       sys_rst_i,
    // register bus
    input  wire axil_req_s  axi_i,
    output axil_rsp_s       axi_o,
    // state machine push side
    input  wire logic       sm_wr_valid_i,
    input  wire logic [7:0] sm_wr_data_i,
    output logic            sm_wr_ready_o,
    // state machine pop side
    output logic            sm_rd_valid_o,
    output logic [7:0]      sm_rd_data_o,
    input  wire logic       sm_rd_ready_i,
    // interrupt
    output logic            irq_o
);

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function automatic logic [5:0] reg_idx(input logic [31:0] a);
        return a[7:2];
    endfunction

    function automatic logic reg_hit(input logic [31:0] a);
        logic [5:0] i;
        i = a[7:2];
        return (a[31:8] == 24'h00_0000) && (a[1:0] == 2'b00) &&
               (i >= IDX_CTRL) && (i <= IDX_IEN);
    endfunction

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [7:0]       mem_q [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d;
    logic [PTR_W-1:0] rd_ptr_q, rd_ptr_d;
    logic [CNT_W-1:0] count_q,  count_d;
    logic             ae_prev_q, ae_prev_d;
    logic             af_prev_q, af_prev_d;

    logic             aw_have_q, aw_have_d;
    logic [31:0]      aw_addr_q, aw_addr_d;
    logic             w_have_q,  w_have_d;
    logic [7:0]       w_data_q,  w_data_d;
    logic             w_lane_q,  w_lane_d;
    logic             b_valid_q, b_valid_d;
    logic [1:0]       b_resp_q,  b_resp_d;

    logic             r_valid_q, r_valid_d;
    logic [31:0]      r_data_q,  r_data_d;
    logic [1:0]       r_resp_q,  r_resp_d;

    logic             limit_q,   limit_d;
    logic [8:0]       wm_q,      wm_d;
    logic             ovf_q,     ovf_d;
    logic [IRQ_W-1:0] stat_q,    stat_d;
    logic [IRQ_W-1:0] ien_q,     ien_d;

    logic             wr_do, reg_wr, ar_take;
    logic [5:0]       wr_idx, rd_idx;
    logic             host_push, host_pop, sm_push, sm_pop;
    logic             push, push_ok, pop_ok, flush;
    logic [7:0]       push_data;
    logic [CNT_W-1:0] cap;
    logic             full, empty, ae, af;
    logic [IRQ_W-1:0] ev;
    logic [31:0]      rd_word;

    // ------------------------------------------------------------------
    // write channel: address and data taken in either order
    // ------------------------------------------------------------------
    // a write executes in the first cycle both halves are held and no answer is pending, then bvalid stands
    always_comb begin
        aw_have_d = aw_have_q;
        aw_addr_d = aw_addr_q;
        w_have_d  = w_have_q;
        w_data_d  = w_data_q;
        w_lane_d  = w_lane_q;
        b_valid_d = b_valid_q;
        b_resp_d  = b_resp_q;
        wr_do     = aw_have_q && w_have_q && !b_valid_q;
        if (axi_i.awvalid && !aw_have_q) begin
            aw_have_d = 1'b1;
            aw_addr_d = axi_i.awaddr;
        end
        if (axi_i.wvalid && !w_have_q) begin
            w_have_d = 1'b1;
            w_data_d = axi_i.wdata[7:0];
            w_lane_d = axi_i.wstrb[0];
        end
        if (b_valid_q && axi_i.bready) begin
            b_valid_d = 1'b0;
        end
        if (wr_do) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            b_valid_d = 1'b1;
            b_resp_d  = reg_hit(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 32'h0000_0000;
            w_have_q  <= 1'b0;
            w_data_q  <= 8'h00;
            w_lane_q  <= 1'b0;
            b_valid_q <= 1'b0;
            b_resp_q  <= RESP_OKAY;
        end else begin
            aw_have_q <= aw_have_d;
            aw_addr_q <= aw_addr_d;
            w_have_q  <= w_have_d;
            w_data_q  <= w_data_d;
            w_lane_q  <= w_lane_d;
            b_valid_q <= b_valid_d;
            b_resp_q  <= b_resp_d;
        end
    end

    // only byte lane 0 carries register data; other lanes are ignored
    assign wr_idx    = reg_idx(aw_addr_q);
    assign reg_wr    = wr_do && reg_hit(aw_addr_q) && w_lane_q;
    assign host_push = reg_wr && (wr_idx == IDX_DATA);
    assign flush     = reg_wr && (wr_idx == IDX_CTRL) && w_data_q[CTRL_FLUSH_POS];

    // ------------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------------
    assign ar_take  = axi_i.arvalid && !r_valid_q;
    assign rd_idx   = reg_idx(axi_i.araddr);
    // a data-port read of an empty fifo answers zero and pops nothing
    assign host_pop = ar_take && reg_hit(axi_i.araddr) && (rd_idx == IDX_DATA) && !empty;

    // read mux; level and watermark upper bits live in buf_ctrl_reg
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (rd_idx)
            IDX_CTRL: begin
                rd_word[CTRL_LIMIT_POS]               = limit_q;
                rd_word[CTRL_WM_HI_POS]               = wm_q[8];
                rd_word[CTRL_AE_POS]                  = ae;
                rd_word[CTRL_AF_POS]                  = af;
                rd_word[CTRL_OVF_POS]                 = ovf_q;
                rd_word[CTRL_FILL_HI_POS+1:CTRL_FILL_HI_POS] = count_q[9:8];
            end
            IDX_WM:   rd_word[7:0] = wm_q[7:0];
            IDX_FILL: rd_word[7:0] = count_q[7:0];
            IDX_DATA: rd_word[7:0] = empty ? 8'h00 : mem_q[rd_ptr_q];
            IDX_STAT: rd_word[IRQ_W-1:0] = stat_q;
            IDX_IEN:  rd_word[IRQ_W-1:0] = ien_q;
            default:  rd_word = 32'h0000_0000;
        endcase
    end

    always_comb begin
        r_valid_d = r_valid_q;
        r_data_d  = r_data_q;
        r_resp_d  = r_resp_q;
        if (r_valid_q && axi_i.rready) begin
            r_valid_d = 1'b0;
        end
        if (ar_take) begin
            r_valid_d = 1'b1;
            r_data_d  = reg_hit(axi_i.araddr) ? rd_word : 32'h0000_0000;
            r_resp_d  = reg_hit(axi_i.araddr) ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            r_valid_q <= 1'b0;
            r_data_q  <= 32'h0000_0000;
            r_resp_q  <= RESP_OKAY;
        end else begin
            r_valid_q <= r_valid_d;
            r_data_q  <= r_data_d;
            r_resp_q  <= r_resp_d;
        end
    end

    // handshakes are combinational, data and responses come from flops
    assign axi_o.awready = !aw_have_q;
    assign axi_o.wready  = !w_have_q;
    assign axi_o.bvalid  = b_valid_q;
    assign axi_o.bresp   = b_resp_q;
    assign axi_o.arready = !r_valid_q;
    assign axi_o.rvalid  = r_valid_q;
    assign axi_o.rdata   = r_data_q;
    assign axi_o.rresp   = r_resp_q;

    // ------------------------------------------------------------------
    // fifo core
    // ------------------------------------------------------------------
    // one array serves both directions; host has priority on either port,
    // so a host push stalls the state machine push, and a host pop its pop, in that cycle
    assign sm_wr_ready_o = !host_push;
    assign sm_push       = sm_wr_valid_i && sm_wr_ready_o;
    assign sm_rd_valid_o = !empty && !host_pop;
    assign sm_rd_data_o  = mem_q[rd_ptr_q];
    assign sm_pop        = sm_rd_valid_o && sm_rd_ready_i;

    assign cap       = limit_q ? CAP_SMALL : CAP_FULL;
    assign full      = count_q >= cap;
    assign empty     = count_q == 10'h000;
    assign push      = host_push || sm_push;
    assign push_data = host_push ? w_data_q : sm_wr_data_i;
    assign push_ok   = push && !full && !flush;
    assign pop_ok    = (host_pop || sm_pop) && !flush;

    // single watermark: top-referenced for full, bottom-referenced for empty
    // full is or-ed in so a level above a freshly lowered cap cannot wrap
    assign af = full || ((cap - count_q) <= {1'b0, wm_q});
    assign ae = count_q <= {1'b0, wm_q};

    always_comb begin
        wr_ptr_d  = wr_ptr_q;
        rd_ptr_d  = rd_ptr_q;
        count_d   = count_q + {9'h000, push_ok} - {9'h000, pop_ok};
        ae_prev_d = ae;
        af_prev_d = af;
        if (push_ok) begin
            wr_ptr_d = PTR_W'(wr_ptr_q + 9'h001);
        end
        if (pop_ok) begin
            rd_ptr_d = PTR_W'(rd_ptr_q + 9'h001);
        end
        if (flush) begin
            wr_ptr_d = '0;
            rd_ptr_d = '0;
            count_d  = '0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_ptr_q  <= '0;
            rd_ptr_q  <= '0;
            count_q   <= '0;
            ae_prev_q <= AE_PREV_RST;
            af_prev_q <= AF_PREV_RST;
        end else begin
            wr_ptr_q  <= wr_ptr_d;
            rd_ptr_q  <= rd_ptr_d;
            count_q   <= count_d;
            ae_prev_q <= ae_prev_d;
            af_prev_q <= af_prev_d;
        end
    end

    // storage has no reset; contents are meaningless until written
    always_ff @(posedge ref_clk_i) begin
        if (push_ok) begin
            mem_q[wr_ptr_q] <= push_data;
        end
    end

    // ------------------------------------------------------------------
    // control registers and interrupt status
    // ------------------------------------------------------------------
    // events: overflow, almost-empty rising, almost-full rising
    assign ev[IRQ_ERR_POS] = push && full;
    assign ev[IRQ_AE_POS]  = ae && !ae_prev_q;
    assign ev[IRQ_AF_POS]  = af && !af_prev_q;

    // a new event wins over a clear written in the same cycle
    always_comb begin
        limit_d = limit_q;
        wm_d    = wm_q;
        ien_d   = ien_q;
        stat_d  = stat_q;
        ovf_d   = ovf_q & !flush;
        if (reg_wr && (wr_idx == IDX_CTRL)) begin
            limit_d  = w_data_q[CTRL_LIMIT_POS];
            wm_d[8]  = w_data_q[CTRL_WM_HI_POS];
        end
        if (reg_wr && (wr_idx == IDX_WM)) begin
            wm_d[7:0] = w_data_q;
        end
        if (reg_wr && (wr_idx == IDX_IEN)) begin
            ien_d = w_data_q[IRQ_W-1:0];
        end
        if (reg_wr && (wr_idx == IDX_CLR)) begin
            stat_d = stat_q & ~w_data_q[IRQ_W-1:0];
        end
        stat_d = stat_d | ev;
        ovf_d  = ovf_d | ev[IRQ_ERR_POS];
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            limit_q <= 1'b0;
            wm_q    <= WM_RST;
            ien_q   <= IEN_RST;
            stat_q  <= '0;
            ovf_q   <= 1'b0;
        end else begin
            limit_q <= limit_d;
            wm_q    <= wm_d;
            ien_q   <= ien_d;
            stat_q  <= stat_d;
            ovf_q   <= ovf_d;
        end
    end

    // level interrupt while any enabled sticky bit is set
    assign irq_o = |(stat_q & ien_q);

endmodule // shared_fifo_watermark

// ===== testbench/shared_fifo_watermark_monitor.sv
// checker for bus answers, stream order and reset state of the shared fifo
`timescale 1ns/1ns
module shared_fifo_watermark_monitor
    import fifo_wm_pkg::*;
(
    // clock and reset
    input wire logic       ref_clk_i,
    input wire logic       sys_rst_i,
    // watched ports
    input wire axil_req_s  axi_i,
    input wire axil_rsp_s  axi_o,
    input wire logic       sm_wr_valid_i,
    input wire logic [7:0] sm_wr_data_i,
    input wire logic       sm_wr_ready_o,
    input wire logic       sm_rd_valid_o,
    input wire logic [7:0] sm_rd_data_o,
    input wire logic       sm_rd_ready_i,
    input wire logic       irq_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    // no host write held and no host read offered, so the fifo moves only by the port
    wire quiet = axi_o.awready && axi_o.wready && !axi_i.arvalid;

    chk_write_answer: assert property ((axi_i.awvalid && axi_o.awready && axi_i.wvalid
        && axi_o.wready && !axi_o.bvalid) |-> ##2 axi_o.bvalid) else $error("write not answered");
    chk_bresp_hold: assert property (axi_o.bvalid && !axi_i.bready
        |=> axi_o.bvalid && $stable(axi_o.bresp)) else $error("write answer dropped");
    chk_rdata_hold: assert property (axi_o.rvalid && !axi_i.rready
        |=> axi_o.rvalid && $stable(axi_o.rdata)) else $error("read answer changed");
    chk_read_answer: assert property (axi_i.arvalid && axi_o.arready
        |=> axi_o.rvalid && !axi_o.arready) else $error("read not answered");
    chk_unmapped_err: assert property (axi_i.arvalid && axi_o.arready
        && axi_i.araddr == 32'h0000_0040 |=> axi_o.rresp == RESP_SLVERR
        && axi_o.rdata == 32'h0000_0000) else $error("hole read not refused");
    chk_push_head: assert property (sm_wr_valid_i && sm_wr_ready_o && !sm_rd_valid_o
        && quiet |=> axi_i.arvalid || (sm_rd_valid_o && sm_rd_data_o == $past(sm_wr_data_i)))
        else $error("pushed byte not at head");
    chk_head_stable: assert property (sm_rd_valid_o && !sm_rd_ready_i && quiet
        |=> axi_i.arvalid || (sm_rd_valid_o && $stable(sm_rd_data_o)))
        else $error("head moved without pop");
    chk_empty_stays: assert property (!sm_rd_valid_o && !sm_wr_valid_i && quiet
        |=> axi_i.arvalid || !sm_rd_valid_o) else $error("empty fifo offered data");
    chk_reset_state: assert property (@(posedge ref_clk_i) disable iff (1'b0) sys_rst_i
        |-> !irq_o && sm_wr_ready_o && !sm_rd_valid_o) else $error("bad reset state");

    cov_irq: cover property ($rose(irq_o));
    cov_slverr: cover property (axi_o.bvalid && axi_o.bresp == RESP_SLVERR);
    cov_pop: cover property (sm_rd_valid_o && sm_rd_ready_i);
endmodule // shared_fifo_watermark_monitor

bind shared_fifo_watermark shared_fifo_watermark_monitor mon (.ref_clk_i, .sys_rst_i,
    .axi_i, .axi_o, .sm_wr_valid_i, .sm_wr_data_i, .sm_wr_ready_o, .sm_rd_valid_o,
    .sm_rd_data_o, .sm_rd_ready_i, .irq_o);

// ===== testbench/sm_partner.sv
// behavioural state machine side: pushes single bytes and drains on request
`timescale 1ns/1ns
module sm_partner (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // bench commands
    input  wire logic        push_i,
    input  wire logic [7:0]  byte_i,
    input  wire logic        drain_i,
    // fifo side
    input  wire logic        wr_ready_i,
    input  wire logic        rd_valid_i,
    input  wire logic [7:0]  rd_data_i,
    output logic             wr_valid_o,
    output logic [7:0]       wr_data_o,
    output logic             rd_ready_o,
    // observed traffic
    output logic [7:0]       last_o,
    output logic [15:0]      count_o
);
    // the bench keeps the host off the data port while this side streams
    assign rd_ready_o = drain_i;
    // byte held until taken; a released data line shows the inverted byte
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_valid_o <= 1'b0;
            wr_data_o  <= 8'h00;
            last_o     <= 8'h00;
            count_o    <= 16'h0000;
        end else begin
            if (push_i && !wr_valid_o) begin
                wr_valid_o <= 1'b1;
                wr_data_o  <= byte_i;
            end else if (wr_valid_o && wr_ready_i) begin
                wr_valid_o <= 1'b0;
                wr_data_o  <= ~wr_data_o;
            end
            if (rd_valid_i && rd_ready_o) begin
                last_o  <= rd_data_i;
                count_o <= count_o + 16'h0001;
            end
        end
    end
endmodule // sm_partner

// ===== testbench/test_shared_fifo_watermark.sv
// self-checking bench for the shared byte fifo over axi4-lite and the state machine port
`timescale 1ns/1ns
module test_shared_fifo_watermark;
    import fifo_wm_pkg::*;
    // ----------------------------------------------------------------
    // clock, reset and wiring
    // ----------------------------------------------------------------
    logic        clk = 1'b0;
    logic        rst;
    axil_req_s   req = '0;
    axil_rsp_s   rsp;
    logic        wr_valid, wr_ready, rd_valid, rd_ready, irq;
    logic        push = 1'b0;
    logic        drain = 1'b0;
    logic [7:0]  wr_data, rd_data, last;
    logic [7:0]  push_byte = 8'h00;
    logic [15:0] count;
    int          mismatches = 0;
    int          comparisons = 0;
    int          cycles = 0;
    always #5 clk = ~clk;

    shared_fifo_watermark uut (.ref_clk_i(clk), .sys_rst_i(rst), .axi_i(req), .axi_o(rsp),
        .sm_wr_valid_i(wr_valid), .sm_wr_data_i(wr_data), .sm_wr_ready_o(wr_ready),
        .sm_rd_valid_o(rd_valid), .sm_rd_data_o(rd_data), .sm_rd_ready_i(rd_ready),
        .irq_o(irq));
    sm_partner sm (.clk_i(clk), .rst_i(rst), .push_i(push), .byte_i(push_byte),
        .drain_i(drain), .wr_ready_i(wr_ready), .rd_valid_i(rd_valid), .rd_data_i(rd_data),
        .wr_valid_o(wr_valid), .wr_data_o(wr_data), .rd_ready_o(rd_ready), .last_o(last),
        .count_o(count));

    function automatic logic [31:0] ad(input logic [5:0] i);
        return {24'h00_0000, i, 2'b00};
    endfunction
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic results();
        if (mismatches == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // whole run needs a few thousand cycles; this ceiling only cuts a hang
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end
    // ----------------------------------------------------------------
    // bus and stream tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_t, w_t;
        @(posedge clk);
        req.awaddr  <= a;
        req.wdata   <= d;
        req.wstrb   <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid  <= 1'b1;
        @(negedge clk);
        while (req.awvalid || req.wvalid) begin
            aw_t = req.awvalid && rsp.awready;
            w_t = req.wvalid && rsp.wready;
            @(posedge clk);
            if (aw_t) req.awvalid <= 1'b0;
            if (w_t) req.wvalid <= 1'b0;
            @(negedge clk);
        end
        while (!rsp.bvalid) @(negedge clk);
        check("bresp", 32'(rsp.bresp), 32'(er));
        // late bready lets the answer wait one cycle, so its hold is exercised
        @(posedge clk);
        req.bready <= 1'b1;
        @(posedge clk);
        req.bready <= 1'b0;
    endtask
    task automatic rd(input string n, input logic [31:0] a, input logic [31:0] e);
        @(posedge clk);
        req.araddr  <= a;
        req.arvalid <= 1'b1;
        @(negedge clk);
        while (!rsp.arready) @(negedge clk);
        @(posedge clk);
        req.arvalid <= 1'b0;
        @(negedge clk);
        while (!rsp.rvalid) @(negedge clk);
        check(n, rsp.rdata, e);
        // late rready keeps read data waiting one cycle
        @(posedge clk);
        req.rready <= 1'b1;
        @(posedge clk);
        req.rready <= 1'b0;
    endtask
    task automatic sm_push(input int n, input logic [7:0] b0);
        for (int k = 0; k < n; k++) begin
            @(posedge clk);
            push_byte <= b0 + 8'(k);
            push <= 1'b1;
            @(posedge clk);
            push <= 1'b0;
            @(negedge clk);
            while (wr_valid) @(negedge clk);
        end
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        // non-blocking so the reset edge reaches every flop at time zero
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd("ctrl", ad(IDX_CTRL), 32'h0000_0008);
        rd("stat", ad(IDX_STAT), 32'h0000_0000);
        rd("hole", 32'h0000_0040, 32'h0000_0000);
        wr(32'h0000_0040, 32'h0000_00FF, RESP_SLVERR);
        wr(ad(IDX_IEN), 32'h0000_0007, RESP_OKAY);
        wr(ad(IDX_WM), 32'h0000_0004, RESP_OKAY);
        for (int k = 0; k < 5; k++) wr(ad(IDX_DATA), 32'h10 + 32'(k), RESP_OKAY);
        rd("fill5", ad(IDX_FILL), 32'h0000_0005);
        rd("ae_off", ad(IDX_CTRL), 32'h0000_0000);
        // one pop by the state machine brings the level back onto the watermark
        @(posedge clk);
        drain <= 1'b1;
        @(posedge clk);
        drain <= 1'b0;
        rd("ae_rise", ad(IDX_STAT), 32'h0000_0002);
        check("irq", 32'(irq), 32'h0000_0001);
        check("head", 32'(last), 32'h0000_0010);
        wr(ad(IDX_CLR), 32'h0000_0002, RESP_OKAY);
        @(negedge clk);
        check("irq_clr", 32'(irq), 32'h0000_0000);
        // capped at 255: alert near the top, then one byte too many
        wr(ad(IDX_CTRL), 32'h0000_0002, RESP_OKAY);
        sm_push(247, 8'h40);
        rd("af_on", ad(IDX_CTRL), 32'h0000_0012);
        rd("af_rise", ad(IDX_STAT), 32'h0000_0004);
        for (int k = 0; k < 5; k++) wr(ad(IDX_DATA), 32'h0000_00A5, RESP_OKAY);
        rd("fill_cap", ad(IDX_FILL), 32'h0000_00FF);
        rd("ovf", ad(IDX_CTRL), 32'h0000_0032);
        rd("err", ad(IDX_STAT), 32'h0000_0005);
        wr(ad(IDX_CLR), 32'h0000_0007, RESP_OKAY);
        // ninth watermark bit: 260 then 256 against a level of 255
        wr(ad(IDX_CTRL), 32'h0000_0004, RESP_OKAY);
        rd("wm260", ad(IDX_CTRL), 32'h0000_003C);
        wr(ad(IDX_WM), 32'h0000_0000, RESP_OKAY);
        rd("wm256", ad(IDX_CTRL), 32'h0000_002C);
        rd("ae_hi", ad(IDX_STAT), 32'h0000_0002);
        wr(ad(IDX_IEN), 32'h0000_0000, RESP_OKAY);
        @(negedge clk);
        check("irq_mask", 32'(irq), 32'h0000_0000);
        wr(ad(IDX_CTRL), 32'h0000_0001, RESP_OKAY);
        rd("flush", ad(IDX_CTRL), 32'h0000_0008);
        rd("fill0", ad(IDX_FILL), 32'h0000_0000);
        // past one byte of level, then drain all and pop the empty fifo once more
        sm_push(300, 8'h00);
        rd("lvl_hi", ad(IDX_CTRL), 32'h0000_0040);
        rd("lvl_lo", ad(IDX_FILL), 32'h0000_002C);
        @(posedge clk);
        drain <= 1'b1;
        @(negedge clk);
        while (rd_valid) @(negedge clk);
        @(posedge clk);
        drain <= 1'b0;
        check("pops", 32'(count), 32'h0000_012D);
        check("tail", 32'(last), 32'h0000_002B);
        rd("empty", ad(IDX_DATA), 32'h0000_0000);
        rd("fill_e", ad(IDX_FILL), 32'h0000_0000);
        results();
    end
endmodule // test_shared_fifo_watermark
